// >>> pmic_watchdog_supervisor.sv
`timescale 1ns/1ps
module pmic_watchdog_supervisor import wd_pkg::*; #(
  parameter int TICK_CYC = TICK_CYCLES
) (
  input wire logic clk, // Clock.
  input wire logic rst_n, // System-level reset.
  input wire logic lock_otp, // Factory lock option.
  input wire logic en_default_otp, // Factory default enable.
  input wire logic psel, // APB select.
  input wire logic penable, // APB enable.
  input wire logic pwrite, // APB direction.
  input wire logic [11:0] paddr, // APB address.
  input wire logic [31:0] pwdata, // APB write data.
  output logic [31:0] prdata, // APB read data.
  output logic pready, // APB ready.
  output logic pslverr, // APB error.
  output logic shutdown_req, // Shutdown request pulse.
  output logic config_reset, // Config reset pulse.
  output logic irq // Interrupt level.
);
  wd_if wd();
  logic [CNT_W-1:0] count;
  logic [1:0] opt_s1, opt_s2;
  logic [1:0] opt_valid;
  logic def_en_reg;
  logic lock_reg, en_reg, action_reg, clr_reg;
  logic [1:0] per_reg;
  logic [FLAG_W-1:0] flags_reg, mask_reg;
  logic wr, rd, hit;
  logic irq_next;

  wd_tick #(.TICK_CYC(TICK_CYC)) u_tick (.clk(clk), .rst_n(rst_n), .wd(wd));
  wd_counter u_cnt (.clk(clk), .rst_n(rst_n), .wd(wd), .count(count));

  // Factory options are pins; they are synchronised before use.
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      opt_s1 <= 2'h0;
      opt_s2 <= 2'h0;
      opt_valid <= 2'h0;
    end else begin
      opt_s1 <= {lock_otp, en_default_otp};
      opt_s2 <= opt_s1;
      // Valid moves through two stages alongside the data so the reset value of opt_s2 is never captured.
      opt_valid <= {opt_valid[0], 1'b1};
    end
  end

  assign wr = psel && penable && pwrite;
  assign rd = psel && penable && !pwrite;
  assign hit = paddr == ADDR_CONFIG || paddr == ADDR_FLAGS || paddr == ADDR_MASK
               || paddr == ADDR_COUNT;

  // Options latched once after release so enable starts at the factory default.
  logic loaded_reg;
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      loaded_reg <= 1'b0;
      lock_reg <= 1'b0;
      en_reg <= 1'b0;
      per_reg <= PERIOD_RESET; // RULE_04
      action_reg <= ACTION_RESET;
    end else if (!loaded_reg) begin
      if (opt_valid[1]) begin
        loaded_reg <= 1'b1;
        lock_reg <= opt_s2[1]; // RULE_06
        en_reg <= opt_s2[0]; // RULE_07
      end
    end else if (wd.expire) begin
      // The configuration reset returns enable to its factory default.
      en_reg <= def_en_reg; // RULE_01 RULE_09
      per_reg <= PERIOD_RESET;
      action_reg <= ACTION_RESET;
    end else if (wr && paddr == ADDR_CONFIG) begin
      per_reg <= pwdata[BIT_PER_LO +: 2]; // RULE_03
      action_reg <= pwdata[BIT_ACTION];
      if (pwdata[BIT_EN]) begin
        en_reg <= 1'b1; // RULE_02 RULE_08
      end else if (!lock_reg) begin
        en_reg <= 1'b0; // RULE_07
      end
    end
  end

  // Records the factory default that every configuration reset restores to enable.
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      def_en_reg <= 1'b0;
    end else if (!loaded_reg && opt_valid[1]) begin
      def_en_reg <= opt_s2[0];
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      clr_reg <= 1'b0;
    end else begin
      clr_reg <= wr && paddr == ADDR_CONFIG && pwdata[BIT_CLR]; // RULE_11
    end
  end

  assign wd.enable = en_reg;
  assign wd.restart = clr_reg; // RULE_05
  assign wd.period = per_reg;

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      shutdown_req <= 1'b0;
      config_reset <= 1'b0;
    end else begin
      shutdown_req <= wd.expire; // RULE_01
      config_reset <= wd.expire;
    end
  end

  // A set in the same cycle as a read-clear wins.
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      flags_reg <= '0;
    end else begin
      flags_reg <= ((rd && paddr == ADDR_FLAGS) ? '0 : flags_reg)
                   | {wd.expire, wd.expire && !action_reg}; // RULE_10
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      mask_reg <= '0;
    end else if (wr && paddr == ADDR_MASK) begin
      mask_reg <= pwdata[FLAG_W-1:0];
    end
  end

  assign irq_next = |(flags_reg & mask_reg);
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      irq <= 1'b0;
    end else begin
      irq <= irq_next;
    end
  end

  // Zero-wait slave: ready is registered and rises in the access cycle.
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      pready <= 1'b0;
      pslverr <= 1'b0;
      prdata <= 32'h0000_0000;
    end else begin
      pready <= psel && !penable;
      pslverr <= psel && !penable && !hit;
      prdata <= 32'h0000_0000;
      if (psel && !penable && !pwrite) begin
        unique case (paddr)
          ADDR_CONFIG: prdata <= 32'({lock_reg, action_reg, per_reg, en_reg, 1'b0}); // RULE_11
          ADDR_FLAGS: prdata <= 32'(flags_reg);
          ADDR_MASK: prdata <= 32'(mask_reg);
          ADDR_COUNT: prdata <= 32'(count);
          default: prdata <= 32'h0000_0000;
        endcase
      end
    end
  end

  chk_expire_shutdown: assert property (@(posedge clk) disable iff (!rst_n)
    wd.expire |=> shutdown_req && config_reset && per_reg == PERIOD_RESET)
    else $error("expiry did not request shutdown"); // RULE_01
  chk_no_run_disabled: assert property (@(posedge clk) disable iff (!rst_n)
    !en_reg |-> !wd.expire) else $error("expiry while disabled"); // RULE_02
  chk_clear_restarts: assert property (@(posedge clk) disable iff (!rst_n)
    clr_reg |=> count == '0) else $error("clear did not restart count"); // RULE_05
  chk_lock_stable: assert property (@(posedge clk) disable iff (!rst_n)
    loaded_reg |=> $stable(lock_reg)) else $error("lock changed"); // RULE_06
  chk_lock_no_off: assert property (@(posedge clk) disable iff (!rst_n)
    loaded_reg && lock_reg && en_reg && !(wd.expire && !def_en_reg) |=> en_reg)
    else $error("locked enable dropped"); // RULE_08
  chk_perm_on: assert property (@(posedge clk) disable iff (!rst_n)
    loaded_reg && lock_reg && def_en_reg |-> en_reg) else $error("permanent enable lost"); // RULE_09
  chk_flag_set: assert property (@(posedge clk) disable iff (!rst_n)
    wd.expire && !action_reg |=> flags_reg[FLAG_WD_OFF]) else $error("off flag not set"); // RULE_10
  chk_clr_pulse: assert property (@(posedge clk) disable iff (!rst_n)
    clr_reg |=> !clr_reg || $past(wr)) else $error("clear strobe stuck"); // RULE_11
  chk_period_ticks: assert property (@(posedge clk) disable iff (!rst_n)
    wd.expire |-> count >= timeout_ticks(per_reg) - CNT_W'(1))
    else $error("wrong timeout"); // RULE_03
endmodule // pmic_watchdog_supervisor

// >>> tb_top.sv
`timescale 1ns/1ps
`define CHK(a, b) begin tests_run++; if ((a) !== (b)) begin n_errors++; \
  $display("ERROR %0t got %h exp %h", $time, a, b); end end
module tb_top;
  import wd_pkg::*;
  logic clk, rst_n, lock_otp, en_default_otp;
  logic psel, penable, pwrite, pready, pslverr, shutdown_req, config_reset, irq;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, rd;
  logic err;
  int n_errors = 0;
  int tests_run = 0;
  int n;

  pmic_watchdog_supervisor #(.TICK_CYC(2)) DUT (.clk(clk), .rst_n(rst_n),
    .lock_otp(lock_otp), .en_default_otp(en_default_otp), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .shutdown_req(shutdown_req), .config_reset(config_reset), .irq(irq));
  wd_host host (.clk(clk), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr));

  initial begin
    clk = 1'b0;
    forever #10 clk = ~clk;
  end

  task automatic close_out();
    if (n_errors == 0 && tests_run > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask

  // Straps are sampled after release, so bus traffic waits five edges.
  task automatic boot(input logic lk, input logic df);
    @(posedge clk);
    rst_n <= 1'b0;
    lock_otp <= lk;
    en_default_otp <= df;
    repeat (6) @(posedge clk);
    rst_n <= 1'b1;
    repeat (5) @(posedge clk);
  endtask

  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    host.xfer(1'b1, a, d, rd, err);
  endtask

  task automatic rchk(input logic [11:0] a, input logic [31:0] x);
    host.xfer(1'b0, a, 32'h0000_0000, rd, err);
    `CHK(rd, x)
  endtask

  initial begin
    #2_000_000;
    n_errors++;
    close_out();
  end

  initial begin
    rst_n = 1'b0;
    lock_otp = 1'b0;
    en_default_otp = 1'b0;
    boot(1'b0, 1'b0);
    rchk(ADDR_CONFIG, 32'h0000_000C);
    wr(ADDR_CONFIG, 32'h0000_0023);
    rchk(ADDR_CONFIG, 32'h0000_0002);
    wr(ADDR_CONFIG, 32'h0000_0000);
    rchk(ADDR_CONFIG, 32'h0000_0000);
    rchk(ADDR_COUNT, 32'h0000_0000);
    host.xfer(1'b0, 12'h010, 32'h0000_0000, rd, err);
    `CHK(err, 1'b1)
    wr(ADDR_MASK, 32'h0000_0003);
    wr(ADDR_CONFIG, 32'h0000_0002);
    repeat (20000) @(posedge clk);
    wr(ADDR_CONFIG, 32'h0000_0003);
    n = 0;
    while (shutdown_req !== 1'b1 && n < 40000) begin
      @(posedge clk);
      n++;
    end
    // The shortest period is 16000 ticks of two cycles, counted from the clear.
    `CHK(n >= 31990 && n <= 32010, 1'b1)
    `CHK(config_reset, 1'b1)
    repeat (3) @(posedge clk);
    `CHK(shutdown_req, 1'b0)
    `CHK(irq, 1'b1)
    wr(ADDR_MASK, 32'h0000_0000);
    repeat (3) @(posedge clk);
    `CHK(irq, 1'b0)
    wr(ADDR_MASK, 32'h0000_0003);
    repeat (3) @(posedge clk);
    `CHK(irq, 1'b1)
    rchk(ADDR_FLAGS, 32'h0000_0003);
    rchk(ADDR_CONFIG, 32'h0000_000C);
    repeat (3) @(posedge clk);
    `CHK(irq, 1'b0)
    boot(1'b1, 1'b0);
    rchk(ADDR_CONFIG, 32'h0000_002C);
    wr(ADDR_CONFIG, 32'h0000_000E);
    rchk(ADDR_CONFIG, 32'h0000_002E);
    wr(ADDR_CONFIG, 32'h0000_000C);
    rchk(ADDR_CONFIG, 32'h0000_002E);
    boot(1'b1, 1'b1);
    rchk(ADDR_CONFIG, 32'h0000_002E);
    wr(ADDR_CONFIG, 32'h0000_000C);
    rchk(ADDR_CONFIG, 32'h0000_002E);
    close_out();
  end
endmodule // tb_top

// >>> wd_counter.sv
`timescale 1ns/1ps
module wd_counter import wd_pkg::*; (
  input wire logic clk, // Clock.
  input wire logic rst_n, // Reset.
  wd_if.cnt wd, // Control side.
  output logic [CNT_W-1:0] count // Elapsed ticks.
);
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      count <= '0;
    end else if (!wd.enable || wd.restart || wd.expire) begin
      count <= '0; // RULE_05
    end else if (wd.tick) begin
      count <= count + CNT_W'(1);
    end
  end
  assign wd.expire = wd.enable && (count >= timeout_ticks(wd.period) - CNT_W'(1)) && wd.tick
                     && !wd.restart; // RULE_01 RULE_03
endmodule // wd_counter

// >>> wd_host.sv
`timescale 1ns/1ps
// Host side of the register bus; one transfer at a time, held until ready.
module wd_host (
  input wire logic clk, // Clock.
  output logic psel, // Select.
  output logic penable, // Enable.
  output logic pwrite, // Direction.
  output logic [11:0] paddr, // Address.
  output logic [31:0] pwdata, // Write data.
  input wire logic [31:0] prdata, // Read data.
  input wire logic pready, // Ready.
  input wire logic pslverr // Error.
);
  initial begin
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 12'h000;
    pwdata = 32'h0000_0000;
  end

  // Read data and the error flag are taken only at the edge where ready is seen.
  task automatic xfer(input logic w, input logic [11:0] a, input logic [31:0] d,
                      output logic [31:0] r, output logic e);
    @(posedge clk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    do @(posedge clk); while (pready !== 1'b1);
    r = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
endmodule // wd_host

// >>> wd_if.sv
`timescale 1ns/1ps
interface wd_if;
  logic tick;
  logic enable;
  logic restart;
  logic [1:0] period;
  logic expire;
  modport ctl(output enable, output restart, output period, input expire, input tick);
  modport cnt(input enable, input restart, input period, output expire, input tick);
  modport div(output tick);
endinterface

// >>> wd_pkg.sv
// Summary of operation
// RULE_01: When the enabled count reaches the timeout with no clear, request shutdown and reset the configuration.
// RULE_02: The watchdog starts only when software writes a one to the enable bit; the code also starts it at boot when the factory default enable is set.
// RULE_03: A two-bit period field picks one of four timeouts from 16 s to 128 s.
// RULE_04: After reset the period field holds the 128 s encoding.
// RULE_05: Software must clear within each period, and each clear restarts the count from zero.
// RULE_06: The lock bit is read-only, comes from the factory, and ignores writes.
// RULE_07: With lock clear, enable resets to its factory default and software may set or clear it.
// RULE_08: With lock set and default off, a write may set enable but not clear it; only system reset clears it. In the code an expiry also clears it.
// RULE_09: With lock and default enable both set, the watchdog can never be disabled.
// RULE_10: An expiry power-off with expiry action zero sets the watchdog-off event flag.
// RULE_11: The clear bit is a self-clearing strobe that reads back as zero.
package wd_pkg;
  localparam logic [11:0] ADDR_CONFIG = 12'h000;
  localparam logic [11:0] ADDR_FLAGS = 12'h004;
  localparam logic [11:0] ADDR_MASK = 12'h008;
  localparam logic [11:0] ADDR_COUNT = 12'h00C;
  localparam int BIT_CLR = 0;
  localparam int BIT_EN = 1;
  localparam int BIT_PER_LO = 2;
  localparam int BIT_ACTION = 4;
  localparam int BIT_LOCK = 5;
  localparam int FLAG_WD_OFF = 0;
  localparam int FLAG_EXPIRED = 1;
  localparam int FLAG_W = 2;
  localparam logic [1:0] PERIOD_RESET = 2'h3;
  localparam logic ACTION_RESET = 1'b0;
  localparam int CLK_HZ = 50_000_000;
  localparam int TICK_MS = 1;
  localparam int TICK_CYCLES = CLK_HZ / 1000 * TICK_MS;
  localparam int TIMEOUT_BASE_S = 16;
  localparam int CNT_W = 18;
  // Period codes double from 16 s up to 128 s.
  function automatic logic [CNT_W-1:0] timeout_ticks(input logic [1:0] per);
    timeout_ticks = CNT_W'((TIMEOUT_BASE_S * 1000 / TICK_MS) << per);
  endfunction
endpackage

// >>> wd_tick.sv
`timescale 1ns/1ps
module wd_tick import wd_pkg::*; #(
  parameter int TICK_CYC = TICK_CYCLES
) (
  input wire logic clk, // Clock.
  input wire logic rst_n, // Reset.
  wd_if.div wd // Tick output.
);
  logic [31:0] div_reg;
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      div_reg <= 32'h0000_0000;
      wd.tick <= 1'b0;
    end else if (div_reg >= 32'(TICK_CYC - 1)) begin
      div_reg <= 32'h0000_0000;
      wd.tick <= 1'b1;
    end else begin
      div_reg <= div_reg + 32'h0000_0001;
      wd.tick <= 1'b0;
    end
  end
endmodule // wd_tick
